// ==== hdl/psr_status_reporter.sv ====
// printer engine status reporter: command receiver, status words, serial reply
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module psr_status_reporter
   import psr_pkg::*;
#(
   parameter int SENSE_CYCLES_P = psr_pkg::SENSE_CYCLES
) (
   input wire logic sys_clk, // system clock
   input wire logic reset, // synchronous reset
   input wire logic clk_en, // freezes all state when low
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write
   input wire logic [7:0] wb_adr_i, // wishbone byte address
   input wire logic [31:0] wb_dat_i, // wishbone write data
   input wire logic [3:0] wb_sel_i, // wishbone byte enables
   output logic [31:0] wb_dat_o, // wishbone read data
   output logic wb_ack_o, // wishbone acknowledge
   input wire logic shift_clk, // serial shift clock from controller
   input wire logic cmd_busy, // controller sending a command
   input wire logic sc_i, // status/command line level
   output logic sc_o, // status/command line drive value
   output logic sc_oe_n, // low while driving the line
   output logic status_busy, // printer sending a status
   input wire logic print_request_line, // print signal from controller
   output logic vertical_sync_request, // vsync request to controller
   output logic ready, // printer ready
   input wire logic drum_turning, // drum rotating normally
   input wire logic scanner_ok, // scanner rotating normally
   input wire logic laser_ready, // laser ready to light
   input wire logic motor_turning, // main motor running
   input wire logic paper_moving, // paper in transport
   input wire logic paper_mid_page, // page being printed
   input wire logic fixer_heating, // fixer below target temperature
   input wire logic fixer_fault, // fixing assembly malfunction
   input wire logic beam_fault, // beam detect malfunction
   input wire logic scanner_fault, // scanner malfunction
   input wire logic laser_temp_fault, // laser temperature control malfunction
   input wire logic motor_fault, // main motor timing malfunction
   input wire logic cartridge_bad, // cartridge missing or misseated
   input wire logic cassette_empty, // cassette empty or absent
   input wire logic jam_sense, // paper jam sensed
   input wire logic misprint_sense, // misprint sensed
   input wire logic test_switch, // test print switch
   output logic engine_power_on, // fixer, motor, scanner, laser enable
   output logic drum_run, // drum rotation command
   output logic paper_eject, // eject unprinted sheet
   output logic manual_feed // manual feed mode selected
);
   import psr_pkg::*;

   function automatic logic odd_bit(input logic [6:0] d);
      odd_bit = ~(^d);
   endfunction

   // two-stage synchronisers for every engine and serial link input; the wishbone inputs are not synchronised
   localparam int NS = 22;
   logic [NS-1:0] sync1_q;
   logic [NS-1:0] sync2_q;
   wire [NS-1:0] raw_in = {shift_clk, cmd_busy, sc_i, print_request_line, drum_turning,
      scanner_ok, laser_ready, motor_turning, paper_moving, paper_mid_page, fixer_heating,
      fixer_fault, beam_fault, scanner_fault, laser_temp_fault, motor_fault, cartridge_bad,
      cassette_empty, jam_sense, misprint_sense, test_switch, 1'b0};
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (clk_en) begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end
   wire s_sclk = sync2_q[21];
   wire s_cbsy = sync2_q[20];
   wire s_sc = sync2_q[19];
   wire s_print = sync2_q[18];
   wire s_drum = sync2_q[17];
   wire s_scan = sync2_q[16];
   wire s_laser = sync2_q[15];
   wire s_motor = sync2_q[14];
   wire s_paper = sync2_q[13];
   wire s_mid = sync2_q[12];
   wire s_heat = sync2_q[11];
   wire [4:0] s_serv = sync2_q[10:6];
   wire s_cart = sync2_q[5];
   wire s_empty = sync2_q[4];
   wire s_jam = sync2_q[3];
   wire s_misp = sync2_q[2];
   wire s_test = sync2_q[1];

   // wishbone slave
   logic [1:0] ctrl_q;
   logic ack_q;
   logic [31:0] rdat_q;
   wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CTRL);
   wire link_en = ctrl_q[CTRL_LINK_EN];

   // engine state
   logic pause_q, pause_pend_q, retx_q, jam_q, call_q, lock_q, test_q;
   logic drum_q, manual_q, eject_q, vsync_req_q, ready_q, print_hold_q, fix_wait_q;
   logic [4:0] serv_q;
   logic [6:0] oper_q;
   logic [$clog2(SENSE_CYCLES_P+1)-1:0] sense_cnt_q;
   wire sense_tick = (sense_cnt_q == '0);

   // command execution strobes, valid only for error-free commands
   logic exec_q;
   logic [7:0] cmd_q;
   wire x_pause = exec_q & (cmd_q == CMD_PAUSE);
   wire x_release = exec_q & (cmd_q == CMD_RELEASE);
   wire x_drum_on = exec_q & (cmd_q == CMD_DRUM_ON);
   wire x_drum_off = exec_q & (cmd_q == CMD_DRUM_OFF);
   wire x_cassette = exec_q & (cmd_q == CMD_CASSETTE);
   wire x_manual = exec_q & (cmd_q == CMD_MANUAL);
   wire x_retx_clr = exec_q & (cmd_q == CMD_RETX_CLR);
   wire x_mode_prn = exec_q & (cmd_q == CMD_MODE_PRN);
   wire x_mode_ctl = exec_q & (cmd_q == CMD_MODE_CTL);

   // status word contents
   wire drum_idle = ~drum_q & ~s_drum;
   wire preq_bit = s_drum & s_scan & s_laser & ~print_hold_q & ~pause_q;
   wire deliv_bit = s_motor & s_paper;
   wire wait_bit = s_heat & ~serv_q[4] & ~pause_q;
   wire [6:0] std_word = {1'b0, preq_bit, deliv_bit, retx_q, wait_bit, pause_q, call_q};
   wire paper_out = s_empty & ~manual_q;
   wire [6:0] oper_d = {1'b0, s_cart, 1'b0, paper_out, jam_q | s_jam, 1'b0, test_q};
   wire serv_any = |serv_q;
   wire fix_pause_now = serv_q[4] & ~s_paper;
   wire other_fault = |serv_q[3:0];
   wire start_test = (s_test | ctrl_q[CTRL_TEST_REQ]) & drum_idle & ready_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sense_cnt_q <= '0;
         print_hold_q <= 1'b0;
         vsync_req_q <= 1'b0;
         drum_q <= 1'b0;
         manual_q <= 1'b0;
      end else if (clk_en) begin
         sense_cnt_q <= sense_tick ? ($bits(sense_cnt_q))'(SENSE_CYCLES_P - 1) :
            sense_cnt_q - 1'b1;
         if (s_print & ~print_hold_q & preq_bit) begin
            print_hold_q <= 1'b1;
         end else if (sense_tick) begin
            print_hold_q <= 1'b0;
         end
         if (~s_print | pause_q) begin
            vsync_req_q <= 1'b0;
         end else if (print_hold_q & sense_tick) begin
            vsync_req_q <= 1'b1;
         end
         // print line has priority over a drum stop
         if (pause_q) begin
            drum_q <= 1'b0;
         end else if (x_drum_on | s_print) begin
            drum_q <= 1'b1;
         end else if (x_drum_off) begin
            drum_q <= 1'b0;
         end
         if (x_manual & ~s_print) begin
            manual_q <= 1'b1;
         end else if (x_cassette & ~s_print) begin
            manual_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pause_q <= 1'b0;
         pause_pend_q <= 1'b0;
         retx_q <= 1'b0;
         jam_q <= 1'b0;
         serv_q <= '0;
         oper_q <= '0;
         call_q <= 1'b0;
         lock_q <= 1'b0;
         test_q <= 1'b0;
         eject_q <= 1'b0;
         ready_q <= 1'b0;
         fix_wait_q <= 1'b0;
      end else if (clk_en) begin
         serv_q <= serv_q | s_serv;
         oper_q <= oper_d;
         if (s_jam) begin
            jam_q <= 1'b1;
         end
         if (s_jam | s_misp) begin
            retx_q <= 1'b1;
         end else if (x_retx_clr) begin
            retx_q <= 1'b0;
         end
         // call follows the registered words one cycle later
         if (oper_q[5] | oper_q[2] | serv_any) begin
            lock_q <= 1'b1;
         end
         call_q <= lock_q | oper_q[5] | oper_q[2] | serv_any | oper_q[3];
         fix_wait_q <= serv_q[4] & s_paper & ~pause_q;
         eject_q <= serv_q[4] & s_paper & ~s_mid & ~pause_q;
         // pending request retires once taken, so a release is not overridden
         if (x_pause) begin
            pause_pend_q <= 1'b1;
         end else if (x_release | pause_q) begin
            pause_pend_q <= 1'b0;
         end
         if (jam_q | other_fault | fix_pause_now) begin
            pause_q <= 1'b1;
         end else if ((pause_pend_q | x_pause) & drum_idle) begin
            pause_q <= 1'b1;
         end else if (x_release & ~serv_any) begin
            pause_q <= 1'b0;
         end
         if (start_test) begin
            test_q <= 1'b1;
         end else if (~s_test & ~ctrl_q[CTRL_TEST_REQ]) begin
            test_q <= 1'b0;
         end
         ready_q <= ~test_q & ~start_test & ~call_q & ~pause_q;
      end
   end

   // serial link: receive on rising, send on falling shift clock edges
   psr_link_type link_q;
   logic sclk_d_q;
   logic [7:0] shreg_q;
   logic [3:0] bitcnt_q;
   logic sbsy_q, sc_o_q, sc_oe_n_q, mode_prn_q, last_err_q;
   psr_sel_type sel;
   wire sclk_rise = s_sclk & ~sclk_d_q;
   wire sclk_fall = ~s_sclk & sclk_d_q;
   wire [7:0] rx = shreg_q;
   wire par_err = (bitcnt_q != BITS_PER_BYTE) | ~(^rx);
   wire is_sr = (rx == CMD_SR0) | (rx == CMD_SR1) | (rx == CMD_SR2) | (rx == CMD_SR4) |
      (rx == CMD_SR5);
   wire is_ec = (rx == CMD_MODE_CTL) | (rx == CMD_MODE_PRN) | (rx == CMD_PAUSE) |
      (rx == CMD_RELEASE) | (rx == CMD_DRUM_ON) | (rx == CMD_DRUM_OFF) |
      (rx == CMD_CASSETTE) | (rx == CMD_MANUAL) | (rx == CMD_RETX_CLR);
   wire cmd_err = par_err | ~(is_sr | is_ec);
   assign sel = (rx == CMD_SR1) ? SEL_OPER : (rx == CMD_SR2) ? SEL_SERV :
      ((rx == CMD_SR4) | (rx == CMD_SR5)) ? SEL_ZERO : SEL_STD;
   wire [6:0] payload = (sel == SEL_OPER) ? oper_q : (sel == SEL_SERV) ? {1'b0, serv_q, 1'b0} :
      (sel == SEL_ZERO) ? 7'h00 : std_word;
   wire [6:0] err_word = {1'b1, par_err, 5'h00};
   wire [6:0] reply7 = cmd_err ? err_word : payload;
   wire [7:0] reply = {reply7, odd_bit(reply7)};

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         link_q <= LNK_IDLE;
         sclk_d_q <= 1'b0;
         shreg_q <= '0;
         bitcnt_q <= '0;
         sbsy_q <= 1'b0;
         sc_o_q <= 1'b0;
         sc_oe_n_q <= 1'b1;
         exec_q <= 1'b0;
         cmd_q <= '0;
         mode_prn_q <= 1'b0;
         last_err_q <= 1'b0;
      end else if (clk_en) begin
         sclk_d_q <= s_sclk;
         exec_q <= 1'b0;
         if (x_mode_prn) begin
            mode_prn_q <= 1'b1;
         end else if (x_mode_ctl) begin
            mode_prn_q <= 1'b0;
         end
         case (link_q)
            LNK_IDLE: begin
               bitcnt_q <= '0;
               if (s_cbsy & link_en) begin
                  link_q <= LNK_RECV;
               end
            end
            LNK_RECV: begin
               if (sclk_rise & (bitcnt_q != BITS_PER_BYTE)) begin
                  shreg_q <= {shreg_q[6:0], s_sc};
                  bitcnt_q <= bitcnt_q + 1'b1;
               end
               if (~s_cbsy) begin
                  shreg_q <= reply;
                  cmd_q <= rx;
                  exec_q <= ~cmd_err & is_ec;
                  last_err_q <= cmd_err;
                  sc_o_q <= reply[7];
                  sc_oe_n_q <= 1'b0;
                  sbsy_q <= 1'b1;
                  bitcnt_q <= '0;
                  link_q <= LNK_SEND;
               end
            end
            LNK_SEND: begin
               if (sclk_rise) begin
                  bitcnt_q <= bitcnt_q + 1'b1;
               end
               if (sclk_fall & (bitcnt_q != BITS_PER_BYTE)) begin
                  shreg_q <= {shreg_q[6:0], 1'b0};
                  sc_o_q <= shreg_q[6];
               end
               if (sclk_fall & (bitcnt_q == BITS_PER_BYTE)) begin
                  sbsy_q <= 1'b0;
                  sc_oe_n_q <= 1'b1;
                  sc_o_q <= 1'b0;
                  link_q <= LNK_IDLE;
               end
            end
            default: link_q <= LNK_IDLE;
         endcase
      end
   end

   // register read path
   wire [31:0] rd_mux = (wb_adr_i == REG_CTRL) ? {30'h0, ctrl_q} :
      (wb_adr_i == REG_STD) ? {24'h0, std_word, odd_bit(std_word)} :
      (wb_adr_i == REG_OPER) ? {24'h0, oper_q, odd_bit(oper_q)} :
      (wb_adr_i == REG_SERV) ? {24'h0, 1'b0, serv_q, 1'b0, odd_bit({1'b0, serv_q, 1'b0})} :
      (wb_adr_i == REG_LINK) ? {20'h0, last_err_q, mode_prn_q, manual_q, pause_q, cmd_q} :
      32'h0;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl_q <= CTRL_RESET;
         ack_q <= 1'b0;
         rdat_q <= '0;
      end else if (clk_en) begin
         ack_q <= wb_req;
         if (wb_req & ~wb_we_i) begin
            rdat_q <= rd_mux;
         end
         if (wr_ctrl) begin
            ctrl_q <= wb_dat_i[1:0];
         end
      end
   end

   // output flops
   logic pwr_q, drum_o_q, eject_o_q, manual_o_q;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pwr_q <= 1'b0;
         drum_o_q <= 1'b0;
         eject_o_q <= 1'b0;
         manual_o_q <= 1'b0;
      end else if (clk_en) begin
         pwr_q <= ~pause_q & link_en;
         drum_o_q <= drum_q & ~pause_q;
         eject_o_q <= eject_q | (fix_wait_q & ~s_mid & s_paper);
         manual_o_q <= manual_q;
      end
   end

   assign wb_dat_o = rdat_q;
   assign wb_ack_o = ack_q;
   assign sc_o = sc_o_q;
   assign sc_oe_n = sc_oe_n_q;
   assign status_busy = sbsy_q;
   assign vertical_sync_request = vsync_req_q;
   assign ready = ready_q;
   assign engine_power_on = pwr_q;
   assign drum_run = drum_o_q;
   assign paper_eject = eject_o_q;
   assign manual_feed = manual_o_q;
endmodule

// ==== hdl/psr_pkg.sv ====
// constants for the printer status reporter
package psr_pkg;
   localparam int CLK_HZ = 40_000_000;
   // print line sensing period and longest print-to-vsync delay
   localparam int SENSE_PERIOD_US = 1000;
   localparam int VSYNC_MAX_MS = 3700;
   localparam int SENSE_CYCLES = SENSE_PERIOD_US * (CLK_HZ / 1_000_000);
   localparam longint VSYNC_MAX_CYCLES = longint'(VSYNC_MAX_MS) * (CLK_HZ / 1000);
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STD = 8'h04;
   localparam logic [7:0] REG_OPER = 8'h08;
   localparam logic [7:0] REG_SERV = 8'h0c;
   localparam logic [7:0] REG_LINK = 8'h10;
   // control fields and reset value
   localparam int CTRL_LINK_EN = 0;
   localparam int CTRL_TEST_REQ = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // command codes, odd parity included
   localparam logic [7:0] CMD_SR0 = 8'h01;
   localparam logic [7:0] CMD_SR1 = 8'h02;
   localparam logic [7:0] CMD_SR2 = 8'h04;
   localparam logic [7:0] CMD_SR4 = 8'h08;
   localparam logic [7:0] CMD_SR5 = 8'h0b;
   localparam logic [7:0] CMD_MODE_CTL = 8'h40;
   localparam logic [7:0] CMD_MODE_PRN = 8'h43;
   localparam logic [7:0] CMD_PAUSE = 8'h45;
   localparam logic [7:0] CMD_RELEASE = 8'h46;
   localparam logic [7:0] CMD_DRUM_ON = 8'h49;
   localparam logic [7:0] CMD_DRUM_OFF = 8'h4a;
   localparam logic [7:0] CMD_CASSETTE = 8'h4c;
   localparam logic [7:0] CMD_MANUAL = 8'h4f;
   localparam logic [7:0] CMD_RETX_CLR = 8'h5d;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   typedef enum logic [1:0] {SEL_STD, SEL_OPER, SEL_SERV, SEL_ZERO} psr_sel_type;
   typedef enum logic [1:0] {LNK_IDLE, LNK_RECV, LNK_SEND} psr_link_type;
endpackage

// ==== sim/psr_status_chk.sv ====
// port checker for the printer status reporter
`timescale 1ns/1ps
module psr_status_chk
   import psr_pkg::*;
#(
   parameter int SENSE_CYCLES_P = psr_pkg::SENSE_CYCLES
) (
   input wire logic sys_clk, // clock
   input wire logic reset, // sync reset
   input wire logic clk_en, // clock enable
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [7:0] wb_adr_i, // address
   input wire logic [31:0] wb_dat_o, // read data
   input wire logic wb_ack_o, // acknowledge
   input wire logic cmd_busy, // controller sending
   input wire logic sc_oe_n, // line drive enable
   input wire logic status_busy, // printer sending
   input wire logic print_request_line, // print signal
   input wire logic vertical_sync_request // vsync request
);
   wire logic req;
   wire logic unmapped;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
   assign unmapped = !(wb_adr_i inside {REG_CTRL, REG_STD, REG_OPER, REG_SERV, REG_LINK});
   default clocking dcb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   chk_ack_next: assert property (req |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
      else $error("ack without request");
   chk_unmapped_zero: assert property (req && !wb_we_i && unmapped |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_reset_quiet: assert property (disable iff (1'b0)
      reset && clk_en |=> sc_oe_n && !status_busy && !wb_ack_o && !vertical_sync_request)
      else $error("outputs active after reset");
   chk_drive_busy: assert property (status_busy |-> !sc_oe_n)
      else $error("status sent without driving the line");
   chk_line_free: assert property (cmd_busy |-> sc_oe_n)
      else $error("line driven during a command");
   chk_reply_soon: assert property ($fell(cmd_busy) |-> ##[2:6] status_busy)
      else $error("no status reply after command");
   chk_busy_release: assert property ($fell(status_busy) |-> sc_oe_n)
      else $error("line held after status end");
   chk_vertical_sync_request_cause: assert property (
      $rose(vertical_sync_request) |-> $past(print_request_line, 2))
      else $error("vsync request without print signal");
   cover property ($fell(status_busy));
   cover property ($rose(vertical_sync_request));
   cover property (wb_ack_o && unmapped);
endmodule

bind psr_status_reporter psr_status_chk #(.SENSE_CYCLES_P(SENSE_CYCLES_P)) u_chk (
   .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .cmd_busy(cmd_busy), .sc_oe_n(sc_oe_n), .status_busy(status_busy),
   .print_request_line(print_request_line),
   .vertical_sync_request(vertical_sync_request)
);

// ==== sim/psr_ctrl_model.sv ====
// controller model: sends a command byte and collects the status reply
`timescale 1ns/1ps
module psr_ctrl_model (
   input wire logic sys_clk, // system clock
   output logic shift_clk, // serial clock, low outside frames
   output logic cmd_busy, // command in progress
   output logic sc_i, // resolved status/command line
   input wire logic sc_o, // printer drive value
   input wire logic sc_oe_n, // printer drive enable, active low
   input wire logic status_busy // printer reply in progress
);
   logic ctl_d;
   assign sc_i = (sc_oe_n === 1'b0) ? sc_o : ctl_d;
   initial begin
      shift_clk = 1'b0;
      cmd_busy = 1'b0;
      ctl_d = 1'b0;
   end
   // half period of the 200 ns shift clock
   task automatic half();
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic xfer(input logic [7:0] c, output logic [7:0] st, output logic ok);
      int n;
      st = 8'h0;
      @(posedge sys_clk);
      cmd_busy <= 1'b1;
      for (int i = 7; i >= 0; i--) begin
         ctl_d <= c[i];
         half();
         shift_clk <= 1'b1;
         half();
         shift_clk <= 1'b0;
      end
      half();
      cmd_busy <= 1'b0;
      ctl_d <= ~ctl_d; // released line shows no stale value
      n = 0;
      while (status_busy !== 1'b1 && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      ok = (status_busy === 1'b1);
      for (int i = 7; i >= 0; i--) begin
         half();
         shift_clk <= 1'b1;
         half();
         st[i] = sc_i; // bit stands through the high phase
         shift_clk <= 1'b0;
      end
      n = 0;
      while (status_busy !== 1'b0 && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      if (status_busy !== 1'b0) begin
         ok = 1'b0;
      end
   endtask
endmodule

// ==== sim/printer_status_reporter_tb.sv ====
// self-checking bench for the printer status reporter
`timescale 1ns/1ps
module printer_status_reporter_tb;
   import psr_pkg::*;
   logic sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, drum_run, paper_eject;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic shift_clk, cmd_busy, sc_i, sc_o, sc_oe_n, status_busy, manual_feed;
   logic print_request_line, vertical_sync_request, ready, engine_power_on;
   logic drum_turning, scanner_ok, laser_ready, motor_turning, paper_moving, fixer_heating;
   logic fixer_fault, beam_fault, scanner_fault, laser_temp_fault, motor_fault;
   logic cartridge_bad, cassette_empty, jam_sense, test_switch;
   wire logic clk_en = 1'b1;
   logic paper_mid_page, misprint_sense;
   logic [19:0] rows [21];
   int bad_count, total_checks;
   psr_status_reporter #(.SENSE_CYCLES_P(50)) u_dut (.*);
   psr_ctrl_model u_ctl (.*);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   function automatic logic [7:0] sb(input logic [7:0] x);
      return {x[7:1], ~^x[7:1]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      if (wb_ack_o !== 1'b1) begin
         bad_count++;
         report_and_stop();
      end
   endtask
   task automatic do_reset();
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      wb(1'b1, REG_CTRL, 32'h1);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] x);
      logic [7:0] st;
      logic ok;
      u_ctl.xfer(c, st, ok);
      check({31'h0, ok}, 32'h1);
      check({24'h0, st}, {24'h0, sb(x)});
   endtask
   task automatic set_eng(input logic [3:0] e);
      {fixer_heating, motor_turning, paper_moving} <= {e[3], e[2], e[2]};
      {drum_turning, scanner_ok, laser_ready, cassette_empty} <= {{3{e[1]}}, e[0]};
   endtask
   initial begin
      {reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {4'h8, 40'h0, 4'hf};
      {paper_mid_page, misprint_sense} = 2'h0;
      {print_request_line, fixer_fault, beam_fault, scanner_fault, laser_temp_fault} = 5'h0;
      {motor_fault, cartridge_bad, jam_sense, test_switch} = 4'h0;
      set_eng(4'h0);
      bad_count = 0;
      total_checks = 0;
      rows = '{{CMD_SR0, 4'h0, 8'h00}, {CMD_SR0, 4'h8, 8'h08},
         {CMD_SR0, 4'h4, 8'h20}, {CMD_SR0, 4'h2, 8'h40},
         {CMD_SR1, 4'h1, 8'h10}, {CMD_SR0, 4'h1, 8'h02},
         {CMD_SR0, 4'h0, 8'h00}, {CMD_SR2, 4'h0, 8'h00},
         {CMD_SR4, 4'h0, 8'h00}, {CMD_SR5, 4'h0, 8'h00},
         {CMD_MODE_CTL, 4'h0, 8'h00}, {CMD_MODE_PRN, 4'h0, 8'h00},
         {CMD_DRUM_ON, 4'h0, 8'h00}, {CMD_DRUM_OFF, 4'h0, 8'h00},
         {CMD_MANUAL, 4'h0, 8'h00}, {CMD_SR1, 4'h1, 8'h00},
         {CMD_CASSETTE, 4'h0, 8'h00}, {CMD_RETX_CLR, 4'h0, 8'h00},
         {8'h07, 4'h0, 8'h80}, {8'h44, 4'h0, 8'hc0},
         {CMD_SR0, 4'h0, 8'h00}};
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      check({sc_oe_n, status_busy, wb_ack_o}, 3'h4);
      wb(1'b0, REG_CTRL, 32'h0);
      check(q, {30'h0, CTRL_RESET});
      wb(1'b1, REG_CTRL, 32'h1);
      foreach (rows[i]) begin
         set_eng(rows[i][11:8]);
         cmd(rows[i][19:12], rows[i][7:0]);
      end
      set_eng(4'h2);
      cmd(CMD_DRUM_ON, 8'h40);
      check(drum_run, 1'b1);
      cmd(CMD_PAUSE, 8'h40);
      cmd(CMD_DRUM_OFF, 8'h40);
      set_eng(4'h0);
      cmd(CMD_SR0, 8'h04);
      check(engine_power_on, 1'b0);
      check(drum_run, 1'b0);
      cmd(CMD_RELEASE, 8'h04);
      cmd(8'h44, 8'hc0);
      cmd(CMD_PAUSE, 8'h00);
      cmd(CMD_SR0, 8'h04);
      cmd(CMD_RELEASE, 8'h04);
      cmd(CMD_SR0, 8'h00);
      check(engine_power_on, 1'b1);
      wb(1'b1, REG_STD, 32'hff);
      wb(1'b0, REG_STD, 32'h0);
      check(q, {24'h0, sb(8'h00)});
      wb(1'b0, 8'h20, 32'h0);
      check(q, 32'h0);
      set_eng(4'h2);
      print_request_line <= 1'b1;
      for (int n = 0; n < 400 && vertical_sync_request !== 1'b1; n++) begin
         @(posedge sys_clk);
      end
      check(vertical_sync_request, 1'b1);
      print_request_line <= 1'b0;
      set_eng(4'h0);
      misprint_sense <= 1'b1;
      cmd(CMD_SR0, 8'h10);
      misprint_sense <= 1'b0;
      cmd(CMD_RETX_CLR, 8'h10);
      cmd(CMD_SR0, 8'h00);
      cmd(CMD_MANUAL, 8'h00);
      check(manual_feed, 1'b1);
      do_reset();
      test_switch <= 1'b1;
      cmd(CMD_SR1, 8'h02);
      check(ready, 1'b0);
      test_switch <= 1'b0;
      do_reset();
      cartridge_bad <= 1'b1;
      cmd(CMD_SR1, 8'h40);
      cartridge_bad <= 1'b0;
      cmd(CMD_SR0, 8'h02);
      jam_sense <= 1'b1;
      cmd(CMD_SR1, 8'h08);
      jam_sense <= 1'b0;
      cmd(CMD_RELEASE, 8'h16);
      cmd(CMD_SR0, 8'h16);
      cmd(CMD_RETX_CLR, 8'h16);
      cmd(CMD_SR0, 8'h06);
      for (int i = 0; i < 5; i++) begin
         do_reset();
         {fixer_fault, beam_fault, scanner_fault, laser_temp_fault, motor_fault} <= 5'h10 >> i;
         cmd(CMD_SR2, 8'h40 >> i);
         {fixer_fault, beam_fault, scanner_fault, laser_temp_fault, motor_fault} <= 5'h0;
         cmd(CMD_SR0, 8'h06);
      end
      do_reset();
      paper_mid_page <= 1'b1;
      set_eng(4'h4);
      fixer_fault <= 1'b1;
      cmd(CMD_SR0, 8'h22);
      check(paper_eject, 1'b0);
      paper_mid_page <= 1'b0;
      cmd(CMD_SR0, 8'h22);
      check(paper_eject, 1'b1);
      set_eng(4'h0);
      cmd(CMD_SR0, 8'h06);
      check(paper_eject, 1'b0);
      fixer_fault <= 1'b0;
      report_and_stop();
   end
endmodule
